// ---- src/mcs_unit.sv ----
/*
 * Control and status logic of a multiply-accumulate unit: status/mode,
 * address modulo, four accumulators with extension halves, overflow and
 * saturation, and formatted accumulator stores.
 * Assumes the core supplies an already extended 48-bit product with its
 * product-overflow flag; register accesses arrive on the core clock.
 */
// Contract
// - Status/mode register, code 0x804, read/write, resets to zero.
// - Address modulo register, code 0x805, read/write, resets to all ones.
// - Accumulators 0..3 at codes 0x806, 0x809, 0x80A, 0x80B, no reset.
// - Extension halves of accumulators 0,1 at 0x807, of 2,3 at 0x808.
// - Every register is selected by a 12-bit register code.
// - Bits 11..8 flag product or 48-bit sum overflow per accumulator.
// - General overflow follows the destination accumulator's flag each operation.
// - A per-accumulator flag holds until a status write clears its bit in 11..8 or a direct load.
// - Bit 7 set forces an overflowing accumulator to a limit constant.
// - A saturated accumulator ignores operations until overflow cleared or loaded.
// - In integer mode bit 6 picks signed or unsigned and limit set.
// - Signed saturation gives 0x7FFF_FFFF or 0x8000_0000 by instruction and sign.
// - Unsigned saturation gives 0x0000_0000 or 0xFFFF_FFFF by instruction.
// - Fraction store with bit 6 clear moves 32 bits without 16-bit rounding.
// - Fraction store with bit 6 set rounds to 16 bits, upper half zero.
// - Store rounding leaves the accumulator unchanged.
// - Status holds a 4-bit mode field and N, Z, V flags.
// - Bit 5 selects fractional operands, else integer.
// - Bit 4 selects rounding or truncation in fractional mode.
// - Bit 1 set on product or 48-bit accumulation overflow.
// - Bit 0 flags overflow of low 32 (integer) or 40 (fraction) bits.
`timescale 1ns/1ns
`default_nettype none
`include "mcs_params.svh"

module mcs_unit
    import mcs_pkg::*;
(
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // Register access by code, shared by core moves and debug port
    input  wire logic                    reg_wr_en,
    input  wire logic                    reg_rd_en,
    input  wire logic [`MCS_CODE_W-1:0]  core_reg_code,
    input  wire logic [31:0]             reg_wdata,
    output logic      [31:0]             reg_rdata,
    output logic                         reg_rd_valid,
    // Arithmetic operation from the pipeline
    input  wire logic                    op_valid,
    input  wire logic                    op_subtract,
    input  wire mcs_acc_sel_t            op_acc_sel,
    input  wire mcs_wide_t               op_product,
    input  wire logic                    op_product_ovf,
    // Accumulator store to a general-purpose register
    input  wire logic                    store_req,
    input  wire mcs_acc_sel_t            store_acc_sel,
    output logic      [31:0]             store_data,
    output logic                         store_valid,
    // Mode outputs to the multiplier and address unit
    output logic                         saturate_enable,
    output logic                         mode_unsigned,
    output logic                         mode_fraction,
    output logic                         mode_round,
    output logic      [31:0]             operand_address_modulo
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [3:0]  ctrl_ff;          // Bits 7..4 of mode_status
    logic [3:0]  cond_ff;          // Bits 3..0: N, Z, V, ext
    logic [3:0]  per_sum_ovf_flags_ff;
    logic [3:0]  sat_held_ff;
    logic [31:0] modulo_ff;
    logic [31:0] accum_ff [4];
    logic [15:0] upper_ff [4];
    logic [31:0] rdata_ff;
    logic        rd_valid_ff;
    logic [31:0] store_data_ff;
    logic        store_valid_ff;

    // ****************************************************************
    // Decode
    // ****************************************************************
    localparam logic [`MCS_CODE_W-1:0] ACC_CODE [4] = '{
        `MCS_CODE_ACCUM0, `MCS_CODE_ACCUM1, `MCS_CODE_ACCUM2, `MCS_CODE_ACCUM3};
    localparam logic [31:0]            RST_STATUS   = `MCS_RST_MODE_STATUS;   // Sliceable reset value

    logic wr_status;
    logic wr_modulo;
    logic wr_up01;
    logic wr_up23;
    logic [3:0] wr_accum;

    // Write strobes per register code
    assign wr_status = reg_wr_en & (core_reg_code == `MCS_CODE_MODE_STATUS);
    assign wr_modulo = reg_wr_en & (core_reg_code == `MCS_CODE_ADDR_MODULO);
    assign wr_up01   = reg_wr_en & (core_reg_code == `MCS_CODE_UPPER01);
    assign wr_up23   = reg_wr_en & (core_reg_code == `MCS_CODE_UPPER23);

    // ****************************************************************
    // Arithmetic on the destination accumulator
    // ****************************************************************
    logic        signed_mode;
    mcs_wide_t   acc_cur;
    logic [48:0] sum49;
    logic        ovf48;
    logic        ovf_any;
    logic        sat_pos;
    mcs_wide_t   sat_val;
    mcs_wide_t   op_result;
    logic        ext_ovf;
    logic        op_hold;
    logic        op_write;

    // Fractions are always signed; integers follow the unsigned bit
    assign signed_mode = mode_fraction | ~mode_unsigned;
    assign acc_cur     = {upper_ff[op_acc_sel], accum_ff[op_acc_sel]};
    assign op_hold     = sat_held_ff[op_acc_sel];
    assign op_write    = op_valid & ~op_hold;

    // 48-bit sum or difference with carry
    assign sum49 = op_subtract ? ({1'b0, acc_cur} - {1'b0, op_product})
                               : ({1'b0, acc_cur} + {1'b0, op_product});

    // Overflow of the 48-bit structure, signed or unsigned
    always_comb begin
        if (signed_mode) begin
            ovf48 = ((acc_cur[47] ^ op_product[47]) == op_subtract) & (sum49[47] != acc_cur[47]);
        end else begin
            ovf48 = sum49[48];
        end
    end
    assign ovf_any = ovf48 | op_product_ovf;

    // Limit constant chosen by instruction, plus product sign in signed mode
    assign sat_pos = (op_product[47] == op_subtract);
    always_comb begin
        if (signed_mode) begin
            sat_val = sat_pos ? {{16{1'b0}}, `MCS_SAT_SIGNED_MAX}
                              : {{16{1'b1}}, `MCS_SAT_SIGNED_MIN};
        end else begin
            sat_val = op_subtract ? {16'h0000, `MCS_SAT_UNSIGNED_MIN}
                                  : {16'h0000, `MCS_SAT_UNSIGNED_MAX};
        end
    end
    assign op_result = (saturate_enable & ovf_any) ? sat_val : sum49[47:0];

    // Extension overflow: result leaves the low 32 or 40 bits
    always_comb begin
        if (mode_fraction) begin
            ext_ovf = ~((&op_result[47:39]) | ~(|op_result[47:39]));
        end else if (signed_mode) begin
            ext_ovf = ~((&op_result[47:31]) | ~(|op_result[47:31]));
        end else begin
            ext_ovf = |op_result[47:32];
        end
    end

    // ****************************************************************
    // Accumulators and extension halves, one per entry
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_acc
            logic wr_up;
            assign wr_accum[g] = reg_wr_en & (core_reg_code == ACC_CODE[g]);
            assign wr_up       = (g < 2) ? wr_up01 : wr_up23;

            // Low 32 bits: direct load wins over an operation
            always_ff @(posedge ref_clk) begin
                if (wr_accum[g]) begin
                    accum_ff[g] <= reg_wdata;
                end else if (op_write && (op_acc_sel == 2'(g))) begin
                    accum_ff[g] <= op_result[31:0];
                end
            end

            // Extension half: odd entry in the upper 16 bits of its pair
            always_ff @(posedge ref_clk) begin
                if (wr_up) begin
                    upper_ff[g] <= reg_wdata[(g % 2) * 16 +: 16];
                end else if (op_write && (op_acc_sel == 2'(g))) begin
                    upper_ff[g] <= op_result[47:32];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Status register
    // ****************************************************************
    logic [3:0] pav_base;
    logic [3:0] pav_set;
    logic [3:0] nxt_pav;
    logic [3:0] nxt_held;
    logic       v_cleared;

    // A status write with V low releases the saturation holds; bits 11..8 load the sticky flags
    assign v_cleared = wr_status & ~reg_wdata[`MCS_BIT_OVF];
    assign pav_base  = (wr_status ? reg_wdata[`MCS_PAV_MSB:`MCS_PAV_LSB] : per_sum_ovf_flags_ff)
                       & ~wr_accum;
    assign pav_set   = (op_write & ovf_any) ? (4'h1 << op_acc_sel) : 4'h0;
    assign nxt_pav   = pav_base | pav_set;

    // Saturated entries hold until overflow is cleared or loaded
    assign nxt_held = ((v_cleared ? 4'h0 : sat_held_ff) & ~wr_accum)
                      | ((op_write & ovf_any & saturate_enable) ? (4'h1 << op_acc_sel) : 4'h0);

    // Mode field and modulo register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_ff   <= RST_STATUS[7:4];
            modulo_ff <= `MCS_RST_ADDR_MODULO;
        end else begin
            if (wr_status) begin
                ctrl_ff <= reg_wdata[`MCS_BIT_SAT_EN:`MCS_BIT_ROUND];
            end
            if (wr_modulo) begin
                modulo_ff <= reg_wdata;
            end
        end
    end

    // Sticky flags and saturation holds; a set wins over a clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            per_sum_ovf_flags_ff <= RST_STATUS[11:8];
            sat_held_ff          <= 4'h0;
        end else begin
            per_sum_ovf_flags_ff <= nxt_pav;
            sat_held_ff          <= nxt_held;
        end
    end

    // Condition flags: operation result overrides a same-cycle write
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cond_ff <= RST_STATUS[3:0];
        end else if (op_valid) begin
            cond_ff[`MCS_BIT_OVF]     <= nxt_pav[op_acc_sel];
            if (op_write) begin
                cond_ff[`MCS_BIT_NEG]     <= op_result[47];
                cond_ff[`MCS_BIT_ZERO]    <= (op_result == 48'h0000_0000_0000);
                cond_ff[`MCS_BIT_EXT_OVF] <= ext_ovf;
            end
        end else if (wr_status) begin
            cond_ff <= reg_wdata[3:0];
        end
    end

    // ****************************************************************
    // Register read path
    // ****************************************************************
    logic [31:0] rd_mux;

    // Read value by code; unmapped codes read zero
    always_comb begin
        case (core_reg_code)
            `MCS_CODE_MODE_STATUS: rd_mux = {{`MCS_RSVD_W{1'b0}}, per_sum_ovf_flags_ff,
                                             ctrl_ff, cond_ff};
            `MCS_CODE_ADDR_MODULO: rd_mux = modulo_ff;
            `MCS_CODE_ACCUM0:      rd_mux = accum_ff[0];
            `MCS_CODE_UPPER01:     rd_mux = {upper_ff[1], upper_ff[0]};
            `MCS_CODE_UPPER23:     rd_mux = {upper_ff[3], upper_ff[2]};
            `MCS_CODE_ACCUM1:      rd_mux = accum_ff[1];
            `MCS_CODE_ACCUM2:      rd_mux = accum_ff[2];
            `MCS_CODE_ACCUM3:      rd_mux = accum_ff[3];
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // Registered read data, one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_ff    <= 32'h0000_0000;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= reg_rd_en;
            if (reg_rd_en) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // ****************************************************************
    // Accumulator store formatting
    // ****************************************************************
    mcs_round_if rnd_bus ();

    // Store format from fraction, unsigned and round bits
    always_comb begin
        rnd_bus.accum = {upper_ff[store_acc_sel], accum_ff[store_acc_sel]};
        if (!mode_fraction) begin
            rnd_bus.mode = MCS_ST_INT;
        end else if (mode_unsigned) begin
            rnd_bus.mode = MCS_ST_RND16;
        end else if (mode_round) begin
            rnd_bus.mode = MCS_ST_RND32;
        end else begin
            rnd_bus.mode = MCS_ST_FULL32;
        end
    end

    mcs_store_round u_round (
        .rnd (rnd_bus.fmt)
    );

    // Registered store value; accumulators are only read here
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            store_data_ff  <= 32'h0000_0000;
            store_valid_ff <= 1'b0;
        end else begin
            store_valid_ff <= store_req;
            if (store_req) begin
                store_data_ff <= rnd_bus.result;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata              = rdata_ff;
    assign reg_rd_valid           = rd_valid_ff;
    assign store_data             = store_data_ff;
    assign store_valid            = store_valid_ff;
    assign saturate_enable        = ctrl_ff[3];
    assign mode_unsigned          = ctrl_ff[2];
    assign mode_fraction          = ctrl_ff[1];
    assign mode_round             = ctrl_ff[0];
    assign operand_address_modulo = modulo_ff;

endmodule

`default_nettype wire

// ---- src/mcs_params.svh ----
/*
 * Constants of the multiply-accumulate control and status block:
 * register codes, status field positions, reset values, limit constants.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// ****************************************************************
// Register codes (12-bit core register code)
// ****************************************************************
`define MCS_CODE_W            12
`define MCS_CODE_MODE_STATUS  12'h804
`define MCS_CODE_ADDR_MODULO  12'h805
`define MCS_CODE_ACCUM0       12'h806
`define MCS_CODE_UPPER01      12'h807
`define MCS_CODE_UPPER23      12'h808
`define MCS_CODE_ACCUM1       12'h809
`define MCS_CODE_ACCUM2       12'h80A
`define MCS_CODE_ACCUM3       12'h80B

// ****************************************************************
// Status register field positions
// ****************************************************************
`define MCS_BIT_EXT_OVF       0
`define MCS_BIT_OVF           1
`define MCS_BIT_ZERO          2
`define MCS_BIT_NEG           3
`define MCS_BIT_ROUND         4
`define MCS_BIT_FRAC          5
`define MCS_BIT_UNSIGNED      6
`define MCS_BIT_SAT_EN        7
`define MCS_PAV_LSB           8
`define MCS_PAV_MSB           11
`define MCS_RSVD_W            20

// ****************************************************************
// Reset values
// ****************************************************************
`define MCS_RST_MODE_STATUS   32'h0000_0000
`define MCS_RST_ADDR_MODULO   32'hFFFF_FFFF

// ****************************************************************
// Saturation limits
// ****************************************************************
`define MCS_SAT_SIGNED_MAX    32'h7FFF_FFFF
`define MCS_SAT_SIGNED_MIN    32'h8000_0000
`define MCS_SAT_UNSIGNED_MIN  32'h0000_0000
`define MCS_SAT_UNSIGNED_MAX  32'hFFFF_FFFF

`endif

// ---- src/mcs_pkg.sv ----
/*
 * Types of the multiply-accumulate control and status block.
 * Assumes nothing of its surroundings.
 */
package mcs_pkg;

    // ****************************************************************
    // Accumulator store formats
    // ****************************************************************
    typedef enum logic [1:0] {
        MCS_ST_INT    = 2'b00,   // Integer, low 32 bits
        MCS_ST_FULL32 = 2'b01,   // Fraction, 32 bits truncated
        MCS_ST_RND32  = 2'b10,   // Fraction, rounded to 32 bits
        MCS_ST_RND16  = 2'b11    // Fraction, rounded to 16 bits
    } mcs_store_mode_t;

    typedef logic [1:0]  mcs_acc_sel_t;
    typedef logic [47:0] mcs_wide_t;

endpackage

// ---- src/mcs_round_if.sv ----
/*
 * Carrier between the control block and its store formatter.
 * Assumes both ends on the same clock; the path is combinational.
 */
`timescale 1ns/1ns
`default_nettype none

interface mcs_round_if;
    import mcs_pkg::*;

    mcs_wide_t       accum;      // Accumulator being stored
    mcs_store_mode_t mode;       // Store format
    logic [31:0]     result;     // Formatted store value

    modport ctrl  (output accum, output mode, input result);
    modport fmt   (input accum, input mode, output result);
endinterface

`default_nettype wire

// ---- src/mcs_store_round.sv ----
/*
 * Accumulator store formatter: truncates or rounds a 48-bit accumulator
 * to the value moved to a general-purpose register.
 * Assumes a combinational path; the accumulator is only read.
 */
`timescale 1ns/1ns
`default_nettype none

module mcs_store_round
    import mcs_pkg::*;
(
    // Formatter side of the carrier
    mcs_round_if.fmt rnd
);

    logic        guard8;
    logic        sticky8;
    logic        guard24;
    logic        sticky24;
    logic [31:0] up32;
    logic [15:0] up16;

    // Round-to-nearest-even terms for both widths
    assign guard8   = rnd.accum[7];
    assign sticky8  = |rnd.accum[6:0];
    assign guard24  = rnd.accum[23];
    assign sticky24 = |rnd.accum[22:0];
    assign up32     = rnd.accum[39:8] + {31'h0, (guard8 & (sticky8 | rnd.accum[8]))};
    assign up16     = rnd.accum[39:24] + {15'h0, (guard24 & (sticky24 | rnd.accum[24]))};

    // Format selection; the accumulator itself is never written here
    always_comb begin
        case (rnd.mode)
            MCS_ST_INT:    rnd.result = rnd.accum[31:0];
            MCS_ST_FULL32: rnd.result = rnd.accum[39:8];
            MCS_ST_RND32:  rnd.result = up32;
            MCS_ST_RND16:  rnd.result = {16'h0000, up16};
            default:       rnd.result = rnd.accum[31:0];
        endcase
    end

endmodule

`default_nettype wire

// ---- tb/mcs_unit_assertions.sv ----
/* Port checker of the multiply-accumulate control block.
   Assumes a bind onto mcs_unit, one clock, synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module mcs_unit_assertions (
    // Clock and reset
    input wire logic        ref_clk, sys_rst,
    // Register bus
    input wire logic        reg_wr_en, reg_rd_en, reg_rd_valid,
    input wire logic [11:0] core_reg_code,
    input wire logic [31:0] reg_wdata, reg_rdata,
    // Store and mode outputs
    input wire logic        store_req, store_valid,
    input wire logic [31:0] store_data, operand_address_modulo,
    input wire logic        saturate_enable, mode_unsigned, mode_fraction, mode_round
);
    // ****************************************************************
    // Port relations
    // ****************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    read_answer_a: assert property (
        reg_rd_en |=> reg_rd_valid) else $error("read not answered");
    read_quiet_a: assert property (
        !reg_rd_en |=> !reg_rd_valid && $stable(reg_rdata)) else $error("read data moved");
    status_rsvd_a: assert property (
        reg_rd_en && core_reg_code == 12'h804 |=> reg_rdata[31:12] == 20'h0) else $error("reserved bits set");
    unmapped_zero_a: assert property (
        reg_rd_en && (core_reg_code < 12'h804 || core_reg_code > 12'h80B) |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    reset_values_a: assert property (
        $fell(sys_rst) |-> operand_address_modulo == 32'hFFFF_FFFF && !saturate_enable && !mode_unsigned
        && !mode_fraction && !mode_round) else $error("reset value wrong");
    mode_write_a: assert property (
        reg_wr_en && core_reg_code == 12'h804 |=> {saturate_enable, mode_unsigned, mode_fraction,
        mode_round} == $past(reg_wdata[7:4])) else $error("mode bits not written");
    mask_write_a: assert property (
        reg_wr_en && core_reg_code == 12'h805 |=> operand_address_modulo == $past(reg_wdata))
        else $error("modulo not written");
    mask_hold_a: assert property (
        !(reg_wr_en && core_reg_code == 12'h805) |=> $stable(operand_address_modulo)) else $error("modulo moved");
    store_answer_a: assert property (
        store_req |=> store_valid) else $error("store not answered");
    store_quiet_a: assert property (
        !store_req |=> !store_valid && $stable(store_data)) else $error("store data moved");
    round_half_a: assert property (
        store_req && mode_fraction && mode_unsigned |=> store_data[31:16] == 16'h0) else $error("upper half set");
endmodule
bind mcs_unit mcs_unit_assertions mcs_unit_assertions_inst (.*);
`default_nettype wire

// ---- tb/mcs_core_model.sv ----
/* Core pipeline and debug port model: register moves, operations, stores.
   Assumes the bench makes the clock; every request starts at a falling edge. */
`timescale 1ns/1ns
`default_nettype none
module mcs_core_model
    import mcs_pkg::*;
(
    // Clock and answers
    input  wire logic         ref_clk,
    input  wire logic  [31:0] reg_rdata, store_data,
    // Requests to the unit
    output logic              reg_wr_en, reg_rd_en, op_valid, op_subtract, op_product_ovf, store_req,
    output logic       [11:0] core_reg_code,
    output logic       [31:0] reg_wdata,
    output mcs_acc_sel_t      op_acc_sel, store_acc_sel,
    output mcs_wide_t         op_product
);
    // Idle requests at time zero
    initial begin
        {reg_wr_en, reg_rd_en, op_valid, op_subtract, op_product_ovf, store_req} = 6'h0;
        {core_reg_code, reg_wdata, op_acc_sel, store_acc_sel, op_product} = 96'h0;
    end
    // Register write; reserved status bits always sent clear
    task automatic wr(input logic [11:0] code, input logic [31:0] d);
        @(negedge ref_clk);
        {reg_wr_en, core_reg_code} = {1'b1, code};
        reg_wdata = (code == 12'h804) ? {20'h0, d[11:0]} : d;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
    endtask
    // Register read, data taken one cycle after the request
    task automatic rd(input logic [11:0] code, output logic [31:0] d);
        @(negedge ref_clk);
        {reg_rd_en, core_reg_code} = {1'b1, code};
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask
    // One arithmetic operation
    task automatic op(input logic [1:0] sel, input logic sub, input logic [47:0] p, input logic ovf);
        @(negedge ref_clk);
        {op_valid, op_acc_sel, op_subtract, op_product, op_product_ovf} = {1'b1, sel, sub, p, ovf};
        @(negedge ref_clk);
        op_valid = 1'b0;
    endtask
    // Accumulator store
    task automatic st(input logic [1:0] sel, output logic [31:0] d);
        @(negedge ref_clk);
        {store_req, store_acc_sel} = {1'b1, sel};
        @(negedge ref_clk);
        store_req = 1'b0;
        d = store_data;
    endtask
endmodule
`default_nettype wire

// ---- tb/test_mcs_unit.sv ----
/* Self-checking bench of the multiply-accumulate control block.
   Assumes the core model and the bound checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module test_mcs_unit;
    import mcs_pkg::*;
    logic         ref_clk, sys_rst, reg_wr_en, reg_rd_en, reg_rd_valid, op_valid, op_subtract;
    logic         op_product_ovf, store_req, store_valid, saturate_enable, mode_unsigned, mode_fraction, mode_round;
    logic  [11:0] core_reg_code;
    logic  [31:0] reg_wdata, reg_rdata, store_data, operand_address_modulo, d;
    mcs_acc_sel_t op_acc_sel, store_acc_sel;
    mcs_wide_t    op_product;
    int           err_count = 0, check_count = 0, cyc = 0;
    mcs_unit mcs_unit_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .core_reg_code(core_reg_code), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .op_valid(op_valid), .op_subtract(op_subtract), .op_acc_sel(op_acc_sel), .op_product(op_product),
        .op_product_ovf(op_product_ovf), .store_req(store_req), .store_acc_sel(store_acc_sel),
        .store_data(store_data), .store_valid(store_valid), .saturate_enable(saturate_enable),
        .mode_unsigned(mode_unsigned), .mode_fraction(mode_fraction), .mode_round(mode_round),
        .operand_address_modulo(operand_address_modulo));
    mcs_core_model core_inst (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .store_data(store_data),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .op_valid(op_valid), .op_subtract(op_subtract),
        .op_product_ovf(op_product_ovf), .store_req(store_req), .core_reg_code(core_reg_code),
        .reg_wdata(reg_wdata), .op_acc_sel(op_acc_sel), .store_acc_sel(store_acc_sel), .op_product(op_product));
    // Clock, reset and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        sys_rst = 1'b1;
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            wrap_up();
        end
    end
    // Verdict and end of run
    task automatic wrap_up();
        if (err_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read and compare data and valid
    task automatic rchk(input logic [11:0] code, input logic [31:0] exp);
        core_inst.rd(code, d);
        chk({31'h0, reg_rd_valid}, 32'h1);
        chk(d, exp);
    endtask
    // Reset values and an unmapped code
    task automatic t_reset();
        rchk(12'h804, 32'h0000_0000);
        rchk(12'h805, 32'hFFFF_FFFF);
        core_inst.wr(12'h803, 32'h1234_5678);
        rchk(12'h803, 32'h0000_0000);
    endtask
    // Write all codes, then read back to catch aliasing
    task automatic t_regs();
        logic [11:0] c [8] = '{12'h804, 12'h805, 12'h806, 12'h807, 12'h808, 12'h809, 12'h80A, 12'h80B};
        foreach (c[i]) core_inst.wr(c[i], {20'hA5C3E, c[i]});
        foreach (c[i]) rchk(c[i], (i == 0) ? 32'h0000_0004 : {20'hA5C3E, c[i]});
        chk(operand_address_modulo, 32'hA5C3_E805);
    endtask
    // Limits per sign mode and instruction, hold, release, extension flag
    task automatic t_sat();
        logic [7:0]  m [4] = '{8'h80, 8'h80, 8'hC0, 8'hC0};
        logic [31:0] l [4] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'hFFFF_FFFF, 32'h0000_0000};
        for (int i = 0; i < 4; i++) begin
            core_inst.wr(12'h804, {24'h0, m[i]});
            core_inst.wr(12'h806, 32'h0000_1000);
            core_inst.op(2'h0, i[0], 48'h1, 1'b1);
            rchk(12'h806, l[i]);
        end
        rchk(12'h804, 32'h0000_01C6);
        core_inst.op(2'h0, 1'b0, 48'h5, 1'b0);
        rchk(12'h806, 32'h0000_0000);
        rchk(12'h804, 32'h0000_01C6);
        core_inst.wr(12'h806, 32'h0000_0010);
        core_inst.op(2'h0, 1'b0, 48'h5, 1'b0);
        rchk(12'h806, 32'h0000_0015);
        rchk(12'h804, 32'h0000_00C0);
        core_inst.wr(12'h804, 32'h0000_0000);
        core_inst.wr(12'h807, 32'h0000_0000);
        core_inst.wr(12'h806, 32'h7FFF_FFFF);
        core_inst.op(2'h0, 1'b0, 48'h1, 1'b0);
        rchk(12'h806, 32'h8000_0000);
        core_inst.rd(12'h804, d);
        chk(d & 32'hFFFF_FFF3, 32'h0000_0001);
    endtask
    // Store formats per mode; the accumulator stays put
    task automatic t_store();
        logic [7:0]  m [4] = '{8'h00, 8'h20, 8'h30, 8'h60};
        logic [31:0] e [4] = '{32'h12C0_0180, 32'hAB12_C001, 32'hAB12_C002, 32'h0000_AB13};
        core_inst.wr(12'h807, 32'h0000_00AB);
        core_inst.wr(12'h806, 32'h12C0_0180);
        for (int i = 0; i < 4; i++) begin
            core_inst.wr(12'h804, {24'h0, m[i]});
            core_inst.st(2'h0, d);
            chk({31'h0, store_valid}, 32'h1);
            chk(d, e[i]);
        end
        rchk(12'h806, 32'h12C0_0180);
    endtask
    // Main sequence
    initial begin
        @(negedge sys_rst);
        t_reset();
        t_regs();
        t_sat();
        t_store();
        wrap_up();
    end
endmodule
`default_nettype wire
